//--- rtl/dtc_defs.svh
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH

// Register indices; byte address is four times the index
`define DTC_IDX_DITH   12'h09D
`define DTC_IDX_LSB    12'h160
`define DTC_IDX_LINK   12'h200
`define DTC_IDX_FMT    12'h300
`define DTC_IDX_STAT   12'h301

// Reset values
`define DTC_RST_DITH   8'h01
`define DTC_RST_LSB    8'h00
`define DTC_RST_LINK   8'h01
`define DTC_RST_FMT    8'h00

// Field positions
`define DTC_DITH_EN    0
`define DTC_DITH_AMP   1
`define DTC_DITH_ERR   2
`define DTC_LSB_MARK   0
`define DTC_LINK_EN    0
`define DTC_FMT_8BIT   0
`define DTC_STAT_NOSYNC 6

// Sample path
`define DTC_SAMPLE_W   12
`define DTC_FIFO_DEPTH 32
`define DTC_MARK12_POS 0
`define DTC_MARK8_POS  4
`define DTC_ILA_CS     2'h0

// Bus
`define DTC_ADDR_W     14
`define DTC_RESP_OKAY  2'h0
`define DTC_RESP_SLVERR 2'h2
`define DTC_LEVEL_W    6

`endif

//--- rtl/dtc_pkg.sv
`include "dtc_defs.svh"

package dtc_pkg;

  typedef struct packed {
    logic                     aw_held;
    logic [11:0]              aw_idx;
    logic                     w_held;
    logic [7:0]               w_data;
    logic                     w_lane0;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     rvalid;
    logic [31:0]              rdata;
    logic [1:0]               rresp;
    logic [7:0]               dith;
    logic [7:0]               lsbc;
    logic [7:0]               link;
    logic [7:0]               fmt;
    logic                     stg_valid;
    logic [`DTC_SAMPLE_W-1:0] stg_data;
  } dtc_state_t;

endpackage

//--- rtl/dtc_fifo.sv
`include "dtc_defs.svh"

module dtc_fifo #(
  parameter int W = `DTC_SAMPLE_W,
  parameter int D = `DTC_FIFO_DEPTH
) (
  // Clock and reset
  input  logic                   aclk,
  input  logic                   aresetn,
  // Fill side
  input  logic                   in_valid,
  output logic                   in_ready,
  input  logic [W-1:0]           in_data,
  // Drain side
  output logic                   out_valid,
  input  logic                   out_ready,
  output logic [W-1:0]           out_data,
  // Fill level, memory plus output register
  output logic [$clog2(D)+1:0]   level
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
    logic                ov;
    logic [W-1:0]        od;
  } dtc_fifo_st_t;

  dtc_fifo_st_t q;
  dtc_fifo_st_t d;
  logic         push;
  logic         pop;
  logic         take;

  assign in_ready  = (q.cnt != D[AW:0]);
  assign out_valid = q.ov;
  assign out_data  = q.od;
  assign level     = {1'b0, q.cnt} + {{(AW+1){1'b0}}, q.ov};

  always_comb
  begin
    d    = q;
    push = in_valid && in_ready;
    take = q.ov && out_ready;
    pop  = (q.cnt != '0) && (!q.ov || take);
    if (push)
    begin
      d.mem[q.wp] = in_data;
      d.wp        = q.wp + 1'b1;
    end
    // Read data leave through a register so the head is always stable
    if (pop)
    begin
      d.od = q.mem[q.rp];
      d.rp = q.rp + 1'b1;
      d.ov = 1'b1;
    end
    else if (take)
      d.ov = 1'b0;
    d.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= '0;
    else
      q <= d;
  end
endmodule

//--- rtl/dtc_top.sv
// What this block does
// [R1] Dither runs while the dither enable bit is set, stops when clear.
// [R2] Amplitude bit 0 selects small dither, 1 selects large dither.
// [R3] Rounding bit 0 puts error into noise; 1 into offset and spurs.
// [R4] With marking enabled, the marker rides in each output sample's LSB.
// [R5] Marker travels with its own sample, so both see equal latency.
// [R6] In 8-bit mode the marker takes the 8-bit sample's LSB.
// [R7] In 12-bit mode the marker takes the 12-bit sample's LSB.
// [R8] Lane alignment always advertises zero control bits per sample.
// [R9] Software also enables the sync receiver when it enables marking.
// [R10] Dither control resets to 0x01.
// [R11] Sample LSB control resets to 0x00.
// [R12] With marking off in 12-bit mode, converter bits pass unchanged, LSB included.
`include "dtc_defs.svh"

module dtc_top
  import dtc_pkg::*;
(
  // Clock and reset
  input  logic                     aclk,
  input  logic                     aresetn,
  // AXI4-Lite write address
  input  logic                     s_axi_awvalid,
  output logic                     s_axi_awready,
  input  logic [`DTC_ADDR_W-1:0]   s_axi_awaddr,
  input  logic [2:0]               s_axi_awprot,
  // AXI4-Lite write data
  input  logic                     s_axi_wvalid,
  output logic                     s_axi_wready,
  input  logic [31:0]              s_axi_wdata,
  input  logic [3:0]               s_axi_wstrb,
  // AXI4-Lite write response
  output logic                     s_axi_bvalid,
  input  logic                     s_axi_bready,
  output logic [1:0]               s_axi_bresp,
  // AXI4-Lite read address
  input  logic                     s_axi_arvalid,
  output logic                     s_axi_arready,
  input  logic [`DTC_ADDR_W-1:0]   s_axi_araddr,
  input  logic [2:0]               s_axi_arprot,
  // AXI4-Lite read data
  output logic                     s_axi_rvalid,
  input  logic                     s_axi_rready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  // Converter samples with their marker
  input  logic                     adc_valid,
  output logic                     adc_ready,
  input  logic [`DTC_SAMPLE_W-1:0] adc_sample,
  input  logic                     adc_marker,
  // Output samples toward the serial link
  output logic                     out_valid,
  input  logic                     out_ready,
  output logic [`DTC_SAMPLE_W-1:0] out_sample,
  // Converter and link controls
  output logic                     dither_on,
  output logic                     dither_amplitude_sel,
  output logic                     rounding_error_sel,
  output logic                     serial_link_enable,
  output logic [1:0]               ila_control_bits,
  input  logic                     sync_receiver_on
);

  dtc_state_t                 q;
  dtc_state_t                 d;
  logic                       aw_fire;
  logic                       w_fire;
  logic                       ar_fire;
  logic                       wr_commit;
  logic                       stage_take;
  logic                       fifo_in_ready;
  logic [`DTC_LEVEL_W:0]      fifo_level;
  logic [11:0]                ar_idx;

  function automatic logic reg_hit(input logic [11:0] idx);
    if (idx == `DTC_IDX_DITH)
      return 1'b1;
    else if (idx == `DTC_IDX_LSB)
      return 1'b1;
    else if (idx == `DTC_IDX_LINK)
      return 1'b1;
    else if (idx == `DTC_IDX_FMT)
      return 1'b1;
    else if (idx == `DTC_IDX_STAT)
      return 1'b1;
    else
      return 1'b0;
  endfunction

  function automatic logic [`DTC_SAMPLE_W-1:0] place_marker(
    input logic [`DTC_SAMPLE_W-1:0] s,
    input logic                     mark,
    input logic                     on,
    input logic                     fmt8
  );
    logic [`DTC_SAMPLE_W-1:0] r;
    r = s;
    // 8-bit samples occupy the upper bits; lower bits carry nothing
    if (fmt8)
      r[`DTC_MARK8_POS-1:0] = '0;
    if (on && fmt8)
      r[`DTC_MARK8_POS] = mark; // R6
    else if (on)
      r[`DTC_MARK12_POS] = mark; // R7
    return r;
  endfunction

  function automatic dtc_state_t rst_state();
    dtc_state_t s;
    s      = '0;
    s.dith = `DTC_RST_DITH; // R10
    s.lsbc = `DTC_RST_LSB; // R11
    s.link = `DTC_RST_LINK;
    s.fmt  = `DTC_RST_FMT;
    return s;
  endfunction

  assign s_axi_awready = !q.aw_held && !q.bvalid;
  assign s_axi_wready  = !q.w_held && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;

  assign aw_fire    = s_axi_awvalid && s_axi_awready;
  assign w_fire     = s_axi_wvalid && s_axi_wready;
  assign ar_fire    = s_axi_arvalid && s_axi_arready;
  assign wr_commit  = q.aw_held && q.w_held && !q.bvalid;
  assign ar_idx     = s_axi_araddr[`DTC_ADDR_W-1:2];
  assign stage_take = !q.stg_valid || fifo_in_ready;
  assign adc_ready  = stage_take;

  assign dither_on            = q.dith[`DTC_DITH_EN]; // R1
  assign dither_amplitude_sel = q.dith[`DTC_DITH_AMP]; // R2
  assign rounding_error_sel   = q.dith[`DTC_DITH_ERR]; // R3
  assign serial_link_enable   = q.link[`DTC_LINK_EN];
  // Marker bit is never advertised, whatever the marking setting
  assign ila_control_bits     = `DTC_ILA_CS; // R8

  always_comb
  begin
    d = q;
    if (aw_fire)
    begin
      d.aw_held = 1'b1;
      d.aw_idx  = s_axi_awaddr[`DTC_ADDR_W-1:2];
    end
    if (w_fire)
    begin
      d.w_held  = 1'b1;
      d.w_data  = s_axi_wdata[7:0];
      d.w_lane0 = s_axi_wstrb[0];
    end
    if (q.bvalid && s_axi_bready)
      d.bvalid = 1'b0;
    if (wr_commit)
    begin
      d.aw_held = 1'b0;
      d.w_held  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = reg_hit(q.aw_idx) ? `DTC_RESP_OKAY : `DTC_RESP_SLVERR;
      // Registers are one byte wide, so only lane 0 can change them
      if (q.w_lane0)
      begin
        if (q.aw_idx == `DTC_IDX_DITH)
          d.dith = q.w_data; // R1 R2 R3
        else if (q.aw_idx == `DTC_IDX_LSB)
          d.lsbc = q.w_data; // R4
        else if (q.aw_idx == `DTC_IDX_LINK)
          d.link = q.w_data;
        else if (q.aw_idx == `DTC_IDX_FMT)
          d.fmt = q.w_data;
      end
    end

    if (q.rvalid && s_axi_rready)
      d.rvalid = 1'b0;
    if (ar_fire)
    begin
      d.rvalid = 1'b1;
      d.rresp  = reg_hit(ar_idx) ? `DTC_RESP_OKAY : `DTC_RESP_SLVERR;
      d.rdata  = '0;
      if (ar_idx == `DTC_IDX_DITH)
        d.rdata[7:0] = q.dith;
      else if (ar_idx == `DTC_IDX_LSB)
        d.rdata[7:0] = q.lsbc;
      else if (ar_idx == `DTC_IDX_LINK)
        d.rdata[7:0] = q.link;
      else if (ar_idx == `DTC_IDX_FMT)
        d.rdata[7:0] = q.fmt;
      else if (ar_idx == `DTC_IDX_STAT)
      begin
        d.rdata[`DTC_LEVEL_W-1:0]   = fifo_level[`DTC_LEVEL_W-1:0];
        d.rdata[`DTC_STAT_NOSYNC]   = q.lsbc[`DTC_LSB_MARK] && !sync_receiver_on; // R9
      end
    end

    // Marker joins its sample here, before any buffering
    if (q.stg_valid && fifo_in_ready)
      d.stg_valid = 1'b0;
    if (adc_valid && stage_take)
    begin
      d.stg_valid = 1'b1;
      d.stg_data  = place_marker(adc_sample, adc_marker, q.lsbc[`DTC_LSB_MARK],
                                 q.fmt[`DTC_FMT_8BIT]); // R4 R5 R12
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= rst_state();
    else
      q <= d;
  end

  // Sample and marker share one word, so the buffer cannot skew them
  dtc_fifo #(
    .W (`DTC_SAMPLE_W),
    .D (`DTC_FIFO_DEPTH)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (q.stg_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (q.stg_data),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_sample),
    .level     (fifo_level)
  ); // R5

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_dith_en;
    wr_commit && q.w_lane0 && (q.aw_idx == `DTC_IDX_DITH)
      |=> dither_on == $past(q.w_data[`DTC_DITH_EN]);
  endproperty
  a_dith_en: assert property (p_dith_en) else $error("dither enable not applied"); // R1

  property p_dith_amp;
    wr_commit && q.w_lane0 && (q.aw_idx == `DTC_IDX_DITH)
      |=> dither_amplitude_sel == $past(q.w_data[`DTC_DITH_AMP]) && s_axi_bvalid;
  endproperty
  a_dith_amp: assert property (p_dith_amp) else $error("amplitude not applied"); // R2

  property p_dith_err;
    $rose(s_axi_bvalid) && (rounding_error_sel != $past(rounding_error_sel))
      |-> $past(q.aw_idx) == `DTC_IDX_DITH;
  endproperty
  a_dith_err: assert property (p_dith_err) else $error("rounding select changed"); // R3

  property p_mark12;
    adc_valid && adc_ready && q.lsbc[`DTC_LSB_MARK] && !q.fmt[`DTC_FMT_8BIT]
      |=> q.stg_valid && q.stg_data[`DTC_MARK12_POS] == $past(adc_marker)
          && q.stg_data[11:1] == $past(adc_sample[11:1]);
  endproperty
  a_mark12: assert property (p_mark12) else $error("12-bit marker misplaced"); // R4 R5 R7

  property p_mark8;
    adc_valid && adc_ready && q.lsbc[`DTC_LSB_MARK] && q.fmt[`DTC_FMT_8BIT]
      |=> q.stg_data[`DTC_MARK8_POS] == $past(adc_marker)
          && q.stg_data[3:0] == 4'h0 && q.stg_data[11:5] == $past(adc_sample[11:5]);
  endproperty
  a_mark8: assert property (p_mark8) else $error("8-bit marker misplaced"); // R6

  property p_pass;
    adc_valid && adc_ready && !q.lsbc[`DTC_LSB_MARK] && !q.fmt[`DTC_FMT_8BIT]
      |=> q.stg_data == $past(adc_sample);
  endproperty
  a_pass: assert property (p_pass) else $error("data altered with marking off"); // R12

  property p_ila;
    ila_control_bits == 2'h0;
  endproperty
  a_ila: assert property (p_ila) else $error("control bits advertised"); // R8

  // Reset checks must see reset itself, so they carry no disable
  property p_rst_dith;
    @(posedge aclk) disable iff (1'b0) !aresetn |=> q.dith == `DTC_RST_DITH && dither_on;
  endproperty
  a_rst_dith: assert property (p_rst_dith) else $error("dither reset value wrong"); // R10

  property p_rst_lsb;
    @(posedge aclk) disable iff (1'b0) !aresetn |=> q.lsbc == `DTC_RST_LSB;
  endproperty
  a_rst_lsb: assert property (p_rst_lsb) else $error("lsb control reset value wrong"); // R11

  property p_stage_hold;
    q.stg_valid && !fifo_in_ready |=> q.stg_valid && $stable(q.stg_data);
  endproperty
  a_stage_hold: assert property (p_stage_hold) else $error("stalled sample lost"); // R5

  c_dith_write: cover property (wr_commit && q.aw_idx == `DTC_IDX_DITH);
  c_stat_read:  cover property (ar_fire && ar_idx == `DTC_IDX_STAT ##1 s_axi_rvalid);
  c_marked:     cover property (adc_valid && adc_ready && q.lsbc[`DTC_LSB_MARK] && adc_marker);
  c_fifo_full:  cover property (q.stg_valid && !fifo_in_ready);

endmodule

//--- dv/dtc_sink.sv
`include "dtc_defs.svh"

module dtc_sink (
  // Clock and reset
  input  logic                     aclk,
  input  logic                     aresetn,
  // Samples from the block
  input  logic                     out_valid,
  output logic                     out_ready,
  input  logic [`DTC_SAMPLE_W-1:0] out_sample,
  // Pace: hold stalls fully, slow takes one cycle in four
  input  logic                     hold,
  input  logic                     slow
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] cnt_q;

  // Registered ready, as a real receiver lane would present it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q     <= 2'h0;
      out_ready <= 1'b0;
    end
    else
    begin
      cnt_q     <= cnt_q + 2'h1;
      out_ready <= !hold && (!slow || cnt_q == 2'h0);
    end
  end
endmodule

//--- dv/tb_top.sv
`include "dtc_defs.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, adc_valid, adc_marker, sync_receiver_on, hold, slow;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        adc_ready, out_valid, out_ready, serial_link_enable;
  logic        dither_on, dither_amplitude_sel, rounding_error_sel;
  logic [13:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed;
  logic [1:0]  s_axi_bresp, s_axi_rresp, ila_control_bits;
  logic [11:0] adc_sample, out_sample;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];
  logic [11:0] sq[$];
  bit          mark_on, fmt8;
  int          fail_count, n_compared, m, v;

  dtc_top dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .adc_valid(adc_valid), .adc_ready(adc_ready), .adc_sample(adc_sample),
    .adc_marker(adc_marker), .out_valid(out_valid), .out_ready(out_ready),
    .out_sample(out_sample), .dither_on(dither_on),
    .dither_amplitude_sel(dither_amplitude_sel), .rounding_error_sel(rounding_error_sel),
    .serial_link_enable(serial_link_enable), .ila_control_bits(ila_control_bits),
    .sync_receiver_on(sync_receiver_on));

  dtc_sink sink (.aclk(aclk), .aresetn(aresetn), .out_valid(out_valid),
    .out_ready(out_ready), .out_sample(out_sample), .hold(hold), .slow(slow));

  always #5 aclk = ~aclk;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [13:0] ba(input logic [11:0] i);
    return {i, 2'h0};
  endfunction

  // Expected sample after marker placement in the current mode
  function automatic logic [11:0] place(input logic [11:0] s, input logic mk);
    if (mark_on && fmt8)
      return {s[11:5], mk, 4'h0};
    if (mark_on)
      return {s[11:1], mk};
    if (fmt8)
      return {s[11:4], 4'h0};
    return s;
  endfunction

  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic hung;
    fail_count++;
    $display("ERROR wait expected done seen timeout");
    finish_test();
  endtask

  task automatic wr(input logic [13:0] a, input logic [7:0] d, input logic [1:0] r);
    int n;
    bq.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    s_axi_bready <= 1'b0;
    if (n == 100)
      hung();
  endtask

  task automatic rd(input logic [13:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    rq.push_back({r, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    s_axi_rready <= 1'b0;
    if (n == 100)
      hung();
  endtask

  // Offers samples back to back; holds each until it is taken
  task automatic stream(input int n);
    int i, g;
    seed = lfsr(seed);
    adc_sample <= seed[11:0];
    adc_marker <= seed[12];
    adc_valid <= 1'b1;
    for (i = 0, g = 0; i < n; g++)
    begin
      @(posedge aclk);
      if (g > 2000)
        hung();
      if (adc_ready)
      begin
        sq.push_back(place(adc_sample, adc_marker));
        i++;
        seed = lfsr(seed);
        adc_sample <= seed[11:0];
        adc_marker <= seed[12];
        adc_valid <= (i < n);
      end
    end
  endtask

  task automatic drain;
    int n;
    for (n = 0; n < 1000 && sq.size() > 0; n++)
      @(posedge aclk);
    if (sq.size() > 0)
      hung();
  endtask

  always @(posedge aclk)
  begin
    if (aresetn && s_axi_bvalid && s_axi_bready)
      chk("bresp", (bq.size() > 0) ? bq.pop_front() : 2'h3, s_axi_bresp);
    if (aresetn && s_axi_rvalid && s_axi_rready)
      chk("rdata", (rq.size() > 0) ? rq.pop_front() : '1, {s_axi_rresp, s_axi_rdata});
    if (aresetn && out_valid && out_ready)
      chk("out_sample", (sq.size() > 0) ? sq.pop_front() : 12'hFFF, out_sample);
  end

  initial
  begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, adc_valid, adc_marker, sync_receiver_on, hold, slow} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, adc_sample} = '0;
    seed = 32'h9122E628;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    chk("dither_on", 1'b1, dither_on);
    chk("serial_link_enable", 1'b1, serial_link_enable);
    rd(ba(`DTC_IDX_DITH), 32'h01, `DTC_RESP_OKAY);
    rd(ba(`DTC_IDX_LSB), 32'h00, `DTC_RESP_OKAY);
    rd(ba(`DTC_IDX_LINK), 32'h01, `DTC_RESP_OKAY);
    $display("test reset_values done");
    for (v = 0; v < 8; v++)
    begin
      seed = lfsr(seed);
      wr(ba(`DTC_IDX_DITH), {seed[7:3], v[2:0]}, `DTC_RESP_OKAY);
      chk("dither_on", v[0], dither_on);
      chk("dither_amplitude_sel", v[1], dither_amplitude_sel);
      chk("rounding_error_sel", v[2], rounding_error_sel);
      rd(ba(`DTC_IDX_DITH), {24'h0, seed[7:3], v[2:0]}, `DTC_RESP_OKAY);
    end
    $display("test dither_fields done");
    wr(ba(12'h0FF), 8'h5A, `DTC_RESP_SLVERR);
    rd(ba(12'h0FF), 32'h0, `DTC_RESP_SLVERR);
    $display("test unmapped done");
    for (m = 0; m < 4; m++)
    begin
      fmt8 = m[0];
      mark_on = m[1];
      wr(ba(`DTC_IDX_FMT), {7'h0, fmt8}, `DTC_RESP_OKAY);
      wr(ba(`DTC_IDX_LSB), {7'h0, mark_on}, `DTC_RESP_OKAY);
      sync_receiver_on <= mark_on;
      slow <= m[0];
      stream(24);
      drain();
      chk("ila_control_bits", `DTC_ILA_CS, ila_control_bits);
      $display("test mode %0d done", m);
    end
    // Stalled receiver: block must fill all 34 places, then refuse
    slow <= 1'b0;
    hold <= 1'b1;
    fork
      stream(40);
      begin
        for (v = 0; v < 300 && adc_ready; v++)
          @(posedge aclk);
        if (v == 300)
          hung();
        chk("accepted_before_refusal", 34, sq.size());
        rd(ba(`DTC_IDX_STAT), 32'h21, `DTC_RESP_OKAY);
        hold <= 1'b0;
      end
    join
    drain();
    $display("test fill_and_drain done");
    sync_receiver_on <= 1'b0;
    rd(ba(`DTC_IDX_STAT), 32'h40, `DTC_RESP_OKAY);
    $display("test status done");
    wr(ba(`DTC_IDX_LINK), 8'h00, `DTC_RESP_OKAY);
    chk("serial_link_enable", 1'b0, serial_link_enable);
    // Mid-run reset must restore defaults over written values
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ba(`DTC_IDX_DITH), 32'h01, `DTC_RESP_OKAY);
    rd(ba(`DTC_IDX_LSB), 32'h00, `DTC_RESP_OKAY);
    rd(ba(`DTC_IDX_LINK), 32'h01, `DTC_RESP_OKAY);
    chk("dither_on", 1'b1, dither_on);
    chk("serial_link_enable", 1'b1, serial_link_enable);
    $display("test mid_reset done");
    finish_test();
  end
endmodule
